//--- bsr_status_bank.sv
// Behaviour
// - second valve cycle counter bytes 0..3 in low byte of indices 15..18.
// - second valve runtime seconds bytes 0..3 in low byte of indices 19..22.
// - error info bytes one and four at indices 23 and 24, kept during fault.
// - index 25 bits 0..3 flame 1, flame 2, flame 2 NC, combined flame.
// - index 25 bits 4..10 air, controller input, valves, ignition, manual, fan.
// - index 25 bit 12 combines controller input with bus heat demand.
// - index 25 bit 15 set while the burner control is faulted.
// - index 26 low byte is sequencer state, or error code during fault.
// - index 26 high byte is flame quality; it and flame 1 read zero in fault.
// - index 27 bits 0..3 mirror heat inputs; bit 4 warns increase and decrease.
// - index 27 bit 10 warns when low fire and high fire are both on.
// - index 27 bits 8..9 give the modulation relay code.
// - index 28 holds modulation percent over 16 bits, kept during fault.
`timescale 1ns/10ps

module bsr_status_bank (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [bsr_pkg::AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [bsr_pkg::DW-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [bsr_pkg::DW-1:0] hrdata,
    // counters
    input wire logic [bsr_pkg::DW-1:0] valve2_cycles,
    input wire logic [bsr_pkg::DW-1:0] valve2_runtime_s,
    // error information
    input wire logic [7:0] err_info_first,
    input wire logic [7:0] err_info_fourth,
    input wire logic [7:0] error_code,
    input wire logic fault,
    // flame and burner signals
    input wire logic flame1,
    input wire logic flame2,
    input wire logic flame2_nc,
    input wire logic flame_detected,
    input wire logic air_pressure_ok,
    input wire logic temp_ctrl_hw,
    input wire logic first_gas_valve,
    input wire logic second_gas_valve,
    input wire logic ignition_on,
    input wire logic manual_on,
    input wire logic fan_on,
    input wire logic [7:0] seq_state,
    input wire logic [7:0] flame_quality,
    // modulation inputs and outputs
    input wire logic heat_inc,
    input wire logic heat_dec,
    input wire logic high_fire,
    input wire logic low_fire,
    input wire logic [1:0] mod_relay,
    input wire logic [15:0] mod_percent,
    // interrupt and heat demand
    output logic irq,
    output logic heat_demand
);
    import bsr_pkg::*;

    bsr_state_type s_r;
    bsr_state_type s_nxt;
    logic [IW-1:0] idx;
    logic mapped;
    logic rd_any;
    logic rd_take;
    logic wr_take;
    logic [1:0] cap;
    logic [1:0][DW-1:0] live;
    logic [1:0][DW-1:0] held;
    logic warn_id;
    logic warn_lh;
    logic tc_comb;
    logic [15:0] w_stat;
    logic [15:0] w_sqfq;
    logic [15:0] w_iow;
    logic [DW-1:0] rd_word;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;

    // address phase decode
    assign idx = haddr[IW+1:2];
    assign mapped = (haddr[AW-1:IW+2] == '0);
    // any read, mapped or not, reloads the read data
    assign rd_any = hsel && htrans[1] && hready && !hwrite;
    assign rd_take = rd_any && mapped;
    assign wr_take = hsel && htrans[1] && hready && hwrite && mapped;

    // counters frozen on a low byte read
    // live counter values and capture strobes
    assign live[0] = valve2_cycles;
    assign live[1] = valve2_runtime_s;
    assign cap[0] = rd_take && (idx == IDX_CYC0);
    assign cap[1] = rd_take && (idx == IDX_RT0);

    // one snapshot holder per counter
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_snap
            bsr_snap u_snap (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .cap(cap[g]),
                .live(live[g]),
                .held(held[g])
            );
        end
    endgenerate

    // warnings and combined controller demand
    // increase decrease warning
    assign warn_id = heat_inc && heat_dec;
    assign warn_lh = low_fire && high_fire;
    assign tc_comb = temp_ctrl_hw && s_r.heat_dmd;

    // packed words, unused bits zero
    always_comb begin
        w_stat = 16'h0000;
        w_stat[B_FLAME1] = flame1 && !fault;
        w_stat[B_FLAME2] = flame2;
        w_stat[B_FLAME2NC] = flame2_nc;
        w_stat[B_FLAMEDET] = flame_detected;
        w_stat[B_AIR] = air_pressure_ok;
        w_stat[B_TCHW] = temp_ctrl_hw;
        w_stat[B_VALVE1] = first_gas_valve;
        w_stat[B_VALVE2] = second_gas_valve;
        w_stat[B_IGN] = ignition_on;
        w_stat[B_MANUAL] = manual_on;
        w_stat[B_FAN] = fan_on;
        w_stat[B_TCCOMB] = tc_comb;
        w_stat[B_FAULT] = fault;
        w_sqfq = 16'h0000;
        w_sqfq[7:0] = fault ? error_code : seq_state;
        w_sqfq[B_QUAL_LO +: 8] = fault ? 8'h00 : flame_quality;
        w_iow = 16'h0000;
        w_iow[3:0] = {low_fire, high_fire, heat_dec, heat_inc};
        w_iow[B_WARN_ID] = warn_id;
        w_iow[B_RELAY_LO +: 2] = mod_relay;
        w_iow[B_WARN_LH] = warn_lh;
    end

    // read data mux, unmapped reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            IDX_CYC0: rd_word[7:0] = valve2_cycles[7:0];
            IDX_CYC1: rd_word[7:0] = held[0][15:8];
            IDX_CYC2: rd_word[7:0] = held[0][23:16];
            IDX_CYC3: rd_word[7:0] = held[0][31:24];
            IDX_RT0: rd_word[7:0] = valve2_runtime_s[7:0];
            IDX_RT1: rd_word[7:0] = held[1][15:8];
            IDX_RT2: rd_word[7:0] = held[1][23:16];
            IDX_RT3: rd_word[7:0] = held[1][31:24];
            IDX_ERR1: rd_word[7:0] = err_info_first;
            IDX_ERR4: rd_word[7:0] = err_info_fourth;
            IDX_STAT: rd_word[15:0] = w_stat;
            IDX_SQFQ: rd_word[15:0] = w_sqfq;
            IDX_IOW: rd_word[15:0] = w_iow;
            IDX_MOD: rd_word[15:0] = mod_percent;
            IDX_INT_STAT: rd_word[NEV-1:0] = s_r.int_stat;
            IDX_INT_MASK: rd_word[NEV-1:0] = s_r.int_mask;
            IDX_HEAT: rd_word[0] = s_r.heat_dmd;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // interrupt events and their clear
    assign ev = {warn_lh, warn_id, fault};
    assign clr = (s_r.dp_wr && (s_r.dp_idx == IDX_INT_STAT)) ? hwdata[NEV-1:0] : '0;

    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.dp_wr = wr_take;
        s_nxt.dp_idx = idx;
        if (rd_any) begin
            s_nxt.rdata = mapped ? rd_word : '0;
        end
        if (s_r.dp_wr && (s_r.dp_idx == IDX_INT_MASK)) begin
            s_nxt.int_mask = hwdata[NEV-1:0];
        end
        if (s_r.dp_wr && (s_r.dp_idx == IDX_HEAT)) begin
            s_nxt.heat_dmd = hwdata[0];
        end
        // rising event sets, set beats clear
        s_nxt.ev_prev = ev;
        s_nxt.int_stat = (s_r.int_stat & ~clr) | (ev & ~s_r.ev_prev);
    end

    // state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= BSR_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // bus answer, zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign irq = |(s_r.int_stat & s_r.int_mask);
    assign heat_demand = s_r.heat_dmd;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence rd_s(logic [IW-1:0] i);
        rd_take && (idx == i);
    endsequence

    sequence fault_read_s;
        rd_take && (idx == IDX_SQFQ) && fault;
    endsequence

    sequence calm_read_s(logic [IW-1:0] i);
        rd_s(i) ##0 !fault;
    endsequence

    sequence ctrl_wr_s(logic [IW-1:0] i);
        s_r.dp_wr && (s_r.dp_idx == i);
    endsequence

    cyc_low_byte_a: assert property (rd_s(IDX_CYC0) |=>
        hrdata == {24'h00_0000, $past(valve2_cycles[7:0])})
        else $error("cycle counter low byte wrong");
    cyc_byte_one_a: assert property (rd_s(IDX_CYC0) ##2 rd_s(IDX_CYC1) |=>
        hrdata == {24'h00_0000, $past(valve2_cycles[15:8], 3)})
        else $error("cycle counter byte one wrong");
    cyc_frozen_a: assert property (rd_s(IDX_CYC0) ##2 rd_s(IDX_CYC3) |=>
        hrdata[7:0] == $past(valve2_cycles[31:24], 3))
        else $error("cycle counter high byte torn");
    rt_low_byte_a: assert property (rd_s(IDX_RT0) |=>
        hrdata == {24'h00_0000, $past(valve2_runtime_s[7:0])})
        else $error("runtime low byte wrong");
    rt_frozen_a: assert property (rd_s(IDX_RT0) ##2 rd_s(IDX_RT1) |=>
        hrdata[7:0] == $past(valve2_runtime_s[15:8], 3))
        else $error("runtime byte one wrong");
    rt_top_byte_a: assert property (rd_s(IDX_RT0) ##2 rd_s(IDX_RT3) |=>
        hrdata[7:0] == $past(valve2_runtime_s[31:24], 3))
        else $error("runtime high byte torn");
    err_first_a: assert property (rd_s(IDX_ERR1) |=>
        hrdata == {24'h00_0000, $past(err_info_first)})
        else $error("first error byte wrong");
    err_info_a: assert property (rd_s(IDX_ERR4) |=>
        hrdata == {24'h00_0000, $past(err_info_fourth)})
        else $error("fourth error byte wrong");
    flame_bits_a: assert property (rd_s(IDX_STAT) |=>
        hrdata[3:1] == $past({flame_detected, flame2_nc, flame2}))
        else $error("flame bits wrong");
    burner_bits_a: assert property (rd_s(IDX_STAT) |=>
        hrdata[B_FAN] == $past(fan_on) && hrdata[B_AIR] == $past(air_pressure_ok))
        else $error("burner bits wrong");
    valve_bits_a: assert property (rd_s(IDX_STAT) |=>
        hrdata[B_IGN:B_TCHW] == $past({ignition_on, second_gas_valve, first_gas_valve,
        temp_ctrl_hw}) && hrdata[B_MANUAL] == $past(manual_on))
        else $error("valve or ignition bits wrong");
    tc_comb_a: assert property (rd_s(IDX_STAT) |=>
        hrdata[B_TCCOMB] == $past(temp_ctrl_hw && heat_demand))
        else $error("combined demand wrong");
    heat_write_a: assert property (ctrl_wr_s(IDX_HEAT) |=> heat_demand == $past(hwdata[0]))
        else $error("heat demand write lost");
    fault_bit_a: assert property (rd_s(IDX_STAT) |=> hrdata[B_FAULT] == $past(fault))
        else $error("fault bit wrong");
    state_code_a: assert property (rd_s(IDX_SQFQ) |=>
        hrdata[7:0] == $past(fault ? error_code : seq_state))
        else $error("state or error code wrong");
    quality_blank_a: assert property (fault_read_s |=> hrdata[15:8] == 8'h00)
        else $error("quality not blanked in fault");
    quality_live_a: assert property (calm_read_s(IDX_SQFQ) |=>
        hrdata[15:8] == $past(flame_quality))
        else $error("flame quality wrong");
    flame_blank_a: assert property (rd_s(IDX_STAT) ##0 fault |=> !hrdata[B_FLAME1])
        else $error("flame one not blanked in fault");
    heat_inputs_a: assert property (rd_s(IDX_IOW) |=>
        hrdata[3:0] == $past({low_fire, high_fire, heat_dec, heat_inc}))
        else $error("heat inputs wrong");
    warn_incdec_a: assert property (rd_s(IDX_IOW) |=>
        hrdata[B_WARN_ID] == $past(heat_inc && heat_dec))
        else $error("increase decrease warning wrong");
    warn_lohi_a: assert property (rd_s(IDX_IOW) |=>
        hrdata[B_WARN_LH] == $past(low_fire && high_fire))
        else $error("low high warning wrong");
    relay_code_a: assert property (rd_s(IDX_IOW) |=> hrdata[9:8] == $past(mod_relay))
        else $error("relay code wrong");
    mod_percent_a: assert property (rd_s(IDX_MOD) |=>
        hrdata == {16'h0000, $past(mod_percent)})
        else $error("modulation percent wrong");
    unused_zero_a: assert property (rd_take && idx >= IDX_CYC0 && idx <= IDX_ERR4 |=>
        hrdata[31:8] == '0)
        else $error("unused bits not zero");
    unmapped_zero_a: assert property (rd_any && !mapped |=> hrdata == '0)
        else $error("unmapped read not zero");
    ro_write_a: assert property (s_r.dp_wr && (s_r.dp_idx inside {[IDX_CYC0:IDX_MOD]}) |=>
        $stable(heat_demand) && $stable(s_r.int_mask))
        else $error("status range write had effect");
    // fault event raises the interrupt when unmasked
    irq_raise_a: assert property ($rose(fault) && s_r.int_mask[EV_FAULT] |=> irq)
        else $error("interrupt not raised");
    // warning event sets its sticky bit
    warn_raise_a: assert property ($rose(low_fire && high_fire) |=> s_r.int_stat[EV_LOHI])
        else $error("low high event not latched");
    // write one clears unless a new event lands
    stat_clear_a: assert property (ctrl_wr_s(IDX_INT_STAT) ##0 hwdata[EV_FAULT] ##0
        !(fault && !s_r.ev_prev[EV_FAULT]) |=> !s_r.int_stat[EV_FAULT])
        else $error("fault status not cleared");

endmodule // bsr_status_bank

//--- bsr_pkg.sv
package bsr_pkg;

    // bus widths
    localparam int DW = 32;
    localparam int AW = 32;
    localparam int IW = 8;
    localparam int NEV = 3;

    // register indices, byte address is four times the index
    localparam logic [IW-1:0] IDX_CYC0 = 8'h0f;
    localparam logic [IW-1:0] IDX_CYC1 = 8'h10;
    localparam logic [IW-1:0] IDX_CYC2 = 8'h11;
    localparam logic [IW-1:0] IDX_CYC3 = 8'h12;
    localparam logic [IW-1:0] IDX_RT0 = 8'h13;
    localparam logic [IW-1:0] IDX_RT1 = 8'h14;
    localparam logic [IW-1:0] IDX_RT2 = 8'h15;
    localparam logic [IW-1:0] IDX_RT3 = 8'h16;
    localparam logic [IW-1:0] IDX_ERR1 = 8'h17;
    localparam logic [IW-1:0] IDX_ERR4 = 8'h18;
    localparam logic [IW-1:0] IDX_STAT = 8'h19;
    localparam logic [IW-1:0] IDX_SQFQ = 8'h1a;
    localparam logic [IW-1:0] IDX_IOW = 8'h1b;
    localparam logic [IW-1:0] IDX_MOD = 8'h1c;
    localparam logic [IW-1:0] IDX_INT_STAT = 8'h20;
    localparam logic [IW-1:0] IDX_INT_MASK = 8'h21;
    localparam logic [IW-1:0] IDX_HEAT = 8'h22;

    // packed burner status word fields
    localparam int B_FLAME1 = 0;
    localparam int B_FLAME2 = 1;
    localparam int B_FLAME2NC = 2;
    localparam int B_FLAMEDET = 3;
    localparam int B_AIR = 4;
    localparam int B_TCHW = 5;
    localparam int B_VALVE1 = 6;
    localparam int B_VALVE2 = 7;
    localparam int B_IGN = 8;
    localparam int B_MANUAL = 9;
    localparam int B_FAN = 10;
    localparam int B_TCCOMB = 12;
    localparam int B_FAULT = 15;

    // inputs, outputs and warnings word fields
    localparam int B_WARN_ID = 4;
    localparam int B_RELAY_LO = 8;
    localparam int B_WARN_LH = 10;

    // state and flame quality word fields
    localparam int B_QUAL_LO = 8;

    // interrupt event bits
    localparam int EV_FAULT = 0;
    localparam int EV_INCDEC = 1;
    localparam int EV_LOHI = 2;

    // main block state
    typedef struct packed {
        logic dp_wr;
        logic [IW-1:0] dp_idx;
        logic [DW-1:0] rdata;
        logic [NEV-1:0] int_stat;
        logic [NEV-1:0] int_mask;
        logic heat_dmd;
        logic [NEV-1:0] ev_prev;
    } bsr_state_type;

    // snapshot holder state
    typedef struct packed {
        logic [DW-1:0] val;
    } bsr_snap_type;

    // reset values
    localparam bsr_state_type BSR_STATE_RST = '0;
    localparam bsr_snap_type BSR_SNAP_RST = '0;

endpackage

//--- bsr_snap.sv
`timescale 1ns/10ps

module bsr_snap (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // capture strobe and live counter
    input wire logic cap,
    input wire logic [bsr_pkg::DW-1:0] live,
    // frozen copy
    output logic [bsr_pkg::DW-1:0] held
);
    import bsr_pkg::*;

    bsr_snap_type s_r;
    bsr_snap_type s_nxt;

    // freeze the whole count when its low byte is read
    always_comb begin
        s_nxt = s_r;
        if (cap) begin
            s_nxt.val = live;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= BSR_SNAP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign held = s_r.val;

endmodule // bsr_snap

//--- bsr_master.sv
`timescale 1ns/10ps

module bsr_master (
    // clock
    input wire logic sys_clk,
    // ahb-lite master outputs
    output logic hsel,
    output logic [bsr_pkg::AW-1:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [bsr_pkg::DW-1:0] hwdata,
    // slave answer
    input wire logic hready,
    input wire logic [bsr_pkg::DW-1:0] hrdata
);
    import bsr_pkg::*;

    // idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one single word transfer, called just after a rising edge
    // packed words keep polling cheap
    task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                        output logic [DW-1:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        // released address lines toggle, never hold a stale value
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= wr ? wd : ~hwdata;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule // bsr_master

//--- bsr_status_bank_bench.sv
`timescale 1ns/10ps

module bsr_status_bank_bench;
    import bsr_pkg::*;
    // clock, bus and design pins
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq, heat_demand, fault;
    logic [1:0] htrans, mod_relay;
    logic [2:0] hsize;
    logic [AW-1:0] haddr;
    logic [DW-1:0] hwdata, hrdata, cyc, rt, rd;
    logic [7:0] err1, err4, code, state, qual;
    logic [14:0] sig;
    logic [15:0] pct;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    bsr_master mst (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    bsr_status_bank uut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .valve2_cycles(cyc),
        .valve2_runtime_s(rt), .err_info_first(err1), .err_info_fourth(err4),
        .error_code(code), .fault(fault), .flame1(sig[0]), .flame2(sig[1]),
        .flame2_nc(sig[2]), .flame_detected(sig[3]), .air_pressure_ok(sig[4]),
        .temp_ctrl_hw(sig[5]), .first_gas_valve(sig[6]), .second_gas_valve(sig[7]),
        .ignition_on(sig[8]), .manual_on(sig[9]), .fan_on(sig[10]), .seq_state(state),
        .flame_quality(qual), .heat_inc(sig[11]), .heat_dec(sig[12]), .high_fire(sig[13]),
        .low_fire(sig[14]), .mod_relay(mod_relay), .mod_percent(pct), .irq(irq),
        .heat_demand(heat_demand));

    task automatic end_of_test();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_idx(input logic [IW-1:0] idx, output logic [DW-1:0] d);
        mst.xfer(1'b0, {22'h0, idx, 2'h0}, 32'h0000_0000, d);
    endtask

    task automatic wr_idx(input logic [IW-1:0] idx, input logic [DW-1:0] d);
        mst.xfer(1'b1, {22'h0, idx, 2'h0}, d, rd);
    endtask

    // expected packed status and io words
    function automatic logic [DW-1:0] exp25(input logic [14:0] s, input logic f, input logic hd);
        return {16'h0000, f, 2'h0, s[5] & hd, 1'b0, s[10:1], s[0] & ~f};
    endfunction

    function automatic logic [DW-1:0] exp27(input logic [14:0] s, input logic [1:0] r);
        return {16'h0000, 5'h00, s[14] & s[13], r, 3'h0, s[11] & s[12], s[14:11]};
    endfunction

    // byte slices of both counters, upper bytes frozen at low byte read
    task automatic test_counters();
        logic [DW-1:0] v;
        for (int k = 0; k < 2; k++) begin
            cyc <= 32'h1234_5678;
            rt <= 32'h9abc_def0;
            v = k ? 32'h9abc_def0 : 32'h1234_5678;
            @(posedge sys_clk);
            rd_idx(IDX_CYC0 + 8'(4 * k), rd);
            check(rd, {24'h00_0000, v[7:0]});
            cyc <= 32'hffff_ffff;
            rt <= 32'hffff_ffff;
            for (int j = 1; j < 4; j++) begin
                rd_idx(IDX_CYC0 + 8'(4 * k + j), rd);
                check(rd, {24'h00_0000, v[8*j +: 8]});
            end
            rd_idx(IDX_CYC0 + 8'(4 * k), rd);
            rd_idx(IDX_CYC0 + 8'(4 * k + 3), rd);
            check(rd, 32'h0000_00ff);
        end
        $display("test_counters done");
    endtask

    // fault hides flame 1 and quality, keeps error bytes and percent
    task automatic test_fault();
        fault <= 1'b1;
        sig <= 15'h7fff;
        {err1, err4, code, state, qual, pct} <= {8'h3c, 8'ha5, 8'h5a, 8'h33, 8'hc4, 16'hbeef};
        @(posedge sys_clk);
        rd_idx(IDX_ERR1, rd);
        check(rd, 32'h0000_003c);
        rd_idx(IDX_ERR4, rd);
        check(rd, 32'h0000_00a5);
        rd_idx(IDX_STAT, rd);
        check(rd, exp25(15'h7fff, 1'b1, 1'b0));
        rd_idx(IDX_SQFQ, rd);
        check(rd, 32'h0000_005a);
        rd_idx(IDX_MOD, rd);
        check(rd, 32'h0000_beef);
        fault <= 1'b0;
        @(posedge sys_clk);
        rd_idx(IDX_STAT, rd);
        check(rd, exp25(15'h7fff, 1'b0, 1'b0));
        rd_idx(IDX_SQFQ, rd);
        check(rd, 32'h0000_c433);
        $display("test_fault done");
    endtask

    // walking one over every input plus warning pairs and relay codes
    // polls packed words
    task automatic test_words();
        logic [14:0] p;
        for (int i = 0; i < 19; i++) begin
            p = i < 15 ? 15'(1 << i) : i == 15 ? 15'h1800 : i == 16 ? 15'h6000 : 15'h7fff;
            sig <= p;
            mod_relay <= 2'(i);
            @(posedge sys_clk);
            rd_idx(IDX_STAT, rd);
            check(rd, exp25(p, 1'b0, 1'b0));
            rd_idx(IDX_IOW, rd);
            check(rd, exp27(p, 2'(i)));
        end
        $display("test_words done");
    endtask

    // controller bit needs both hardware input and bus demand
    task automatic test_heat();
        sig <= 15'h0020;
        wr_idx(IDX_HEAT, 32'h0000_0001);
        @(posedge sys_clk);
        check({31'h0, heat_demand}, 32'h0000_0001);
        rd_idx(IDX_STAT, rd);
        check(rd, exp25(15'h0020, 1'b0, 1'b1));
        wr_idx(IDX_HEAT, 32'h0000_0000);
        rd_idx(IDX_STAT, rd);
        check(rd, exp25(15'h0020, 1'b0, 1'b0));
        $display("test_heat done");
    endtask

    // writes to status range ignored, unmapped reads zero
    task automatic test_ro();
        sig <= 15'h0155;
        @(posedge sys_clk);
        wr_idx(IDX_STAT, 32'hffff_ffff);
        wr_idx(IDX_CYC0, 32'hffff_ffff);
        rd_idx(IDX_STAT, rd);
        check(rd, exp25(15'h0155, 1'b0, 1'b0));
        mst.xfer(1'b0, 32'h0000_0400, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        rd_idx(8'h3f, rd);
        check(rd, 32'h0000_0000);
        check({30'h0, hresp, hreadyout}, 32'h0000_0001);
        $display("test_ro done");
    endtask

    // sticky events, mask and write one to clear
    task automatic test_irq();
        sig <= 15'h0000;
        wr_idx(IDX_INT_STAT, 32'h0000_0007);
        wr_idx(IDX_INT_MASK, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        fault <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0001);
        wr_idx(IDX_INT_STAT, 32'h0000_0001);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0000);
        sig <= 15'h1800;
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0000);
        sig <= 15'h7800;
        // let the new warning latch before the status read
        @(posedge sys_clk);
        rd_idx(IDX_INT_STAT, rd);
        check(rd, 32'h0000_0006);
        wr_idx(IDX_INT_MASK, 32'h0000_0007);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0001);
        wr_idx(IDX_INT_STAT, 32'h0000_0006);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0000);
        fault <= 1'b0;
        $display("test_irq done");
    endtask

    // main sequence
    initial begin
        {fault, sig, mod_relay, pct} = '0;
        {cyc, rt, err1, err4, code, state, qual} = '0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        test_counters();
        test_fault();
        test_words();
        test_heat();
        test_ro();
        test_irq();
        end_of_test();
    end
endmodule // bsr_status_bank_bench
